// ==== src/fps_host.sv ====
// Host controller that drives the flash pins for program, erase, protect.
`timescale 1ns/1ps
`include "fps_map.svh"

module fps_host
    import fps_pkg::*;
#(
    parameter longint unsigned CHIP_CYC =
        64'(`FPS_CHIP_MAX_S) * 1000000 * `FPS_CLK_MHZ,
    parameter longint unsigned SECT_CYC =
        64'(`FPS_SECT_MAX_S) * 1000000 * `FPS_CLK_MHZ,
    parameter int unsigned PROG_CYC = `FPS_CYC_US(`FPS_PROG_MAX_US),
    parameter int unsigned LOAD_CYC = `FPS_CYC_US(`FPS_LOAD_US),
    parameter int unsigned PROT_CYC = `FPS_CYC_US(`FPS_PROT_US),
    parameter int unsigned UNPROT_CYC = `FPS_CYC_US(`FPS_UNPROT_MS * 1000),
    parameter int unsigned OELEAD_CYC = `FPS_CYC_US(`FPS_OELEAD_US)
) (
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_rstn,
    // User request and status.
    input wire logic i_start,
    input wire logic [2:0] i_op,
    input wire logic [16:0] i_addr,
    input wire logic [7:0] i_data,
    input wire logic i_use_toggle,
    output logic o_busy,
    output logic o_done,
    output logic o_timeout,
    // Flash pins.
    output logic [16:0] o_flash_addr,
    input wire logic [7:0] i_flash_dq,
    output logic [7:0] o_flash_dq,
    output logic o_flash_dq_oe,
    output logic o_flash_ce_n,
    output logic o_flash_oe_n,
    output logic o_flash_we_n
);

    // ----------------------------------------
    // Command tables and helpers
    // ----------------------------------------
    // Returns the address of command write k for the given operation.
    function automatic logic [16:0] cmd_addr(input logic [2:0] op,
                                            input logic [2:0] k,
                                            input logic [16:0] a);
        logic [16:0] r;
        r = (k == 3'h1 || k == 3'h4) ? 17'h002AA : 17'h00555;
        if (op == FPS_OP_PROG && k == 3'h3) begin
            r = a;
        end else if (op == FPS_OP_SECT && k == 3'h5) begin
            r = {a[`FPS_SECT_HI:`FPS_SECT_LO], 13'h0000};
        end
        return r;
    endfunction

    // Returns the data of command write k for the given operation.
    function automatic logic [7:0] cmd_data(input logic [2:0] op,
                                           input logic [2:0] k,
                                           input logic [7:0] d);
        logic [7:0] r;
        case (k)
            3'h0: r = 8'hAA;
            3'h1: r = 8'h55;
            3'h2: r = (op == FPS_OP_PROG) ? 8'hA0 : 8'h80;
            3'h3: r = (op == FPS_OP_PROG) ? d : 8'hAA;
            3'h4: r = 8'h55;
            default: r = (op == FPS_OP_SECT) ? 8'h30 : 8'h10;
        endcase
        return r;
    endfunction

    // Number of command writes minus one for an operation.
    function automatic logic [2:0] cmd_last(input logic [2:0] op);
        return (op == FPS_OP_PROG) ? 3'h3 : 3'h5;
    endfunction

    fps_state_e state_ff;
    logic [2:0] op_ff;
    logic [2:0] idx_ff;
    logic [16:0] addr_ff;
    logic [7:0] data_ff;
    logic tog_ff;
    logic [7:0] prev_ff;
    logic have_prev_ff;
    logic [32:0] cnt_ff; // Wide enough for the longest chip erase.
    logic [32:0] wait_ff;
    logic [4:0] stb_ff;
    logic done_now;
    logic [32:0] op_limit;

    // Completion test on the sampled status byte.
    always_comb begin
        if (tog_ff) begin
            done_now = have_prev_ff && (prev_ff[`FPS_TOGGLE_BIT] ==
                i_flash_dq[`FPS_TOGGLE_BIT]);
        end else if (op_ff == FPS_OP_PROG) begin
            done_now = (i_flash_dq[`FPS_POLL_BIT] ==
                data_ff[`FPS_POLL_BIT]);
        end else begin
            done_now = i_flash_dq[`FPS_POLL_BIT];
        end
    end

    // Longest time allowed for the running operation.
    always_comb begin
        case (op_ff)
            FPS_OP_CHIP: op_limit = 33'(CHIP_CYC);
            FPS_OP_SECT: op_limit = 33'(SECT_CYC + LOAD_CYC);
            default: op_limit = 33'(PROG_CYC);
        endcase
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    // Main state machine; each strobe phase lasts a fixed cycle count.
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            state_ff <= FPS_IDLE;
            op_ff <= FPS_OP_PROG;
            idx_ff <= 3'h0;
            addr_ff <= 17'h00000;
            data_ff <= 8'h00;
            tog_ff <= 1'b0;
            stb_ff <= 5'h00;
            wait_ff <= 33'h0;
            prev_ff <= 8'h00;
            have_prev_ff <= 1'b0;
        end else begin
            case (state_ff)
                FPS_IDLE: begin
                    stb_ff <= 5'h00;
                    idx_ff <= 3'h0;
                    have_prev_ff <= 1'b0;
                    if (i_start) begin
                        op_ff <= i_op;
                        addr_ff <= i_addr;
                        data_ff <= i_data;
                        tog_ff <= i_use_toggle;
                        wait_ff <= 33'h0;
                        state_ff <= (i_op == FPS_OP_PROT ||
                            i_op == FPS_OP_UNPROT) ? FPS_OE_LEAD : FPS_CMD;
                    end
                end
                FPS_CMD: begin
                    stb_ff <= stb_ff + 5'h01;
                    if (stb_ff == 5'(`FPS_STROBE_CYC - 1)) begin
                        stb_ff <= 5'h00;
                        state_ff <= FPS_CMD_GAP;
                    end
                end
                FPS_CMD_GAP: begin
                    stb_ff <= stb_ff + 5'h01;
                    if (stb_ff == 5'(`FPS_STROBE_CYC - 1)) begin
                        stb_ff <= 5'h00;
                        if (idx_ff == cmd_last(op_ff)) begin
                            state_ff <= (op_ff == FPS_OP_SECT) ?
                                FPS_LOAD : FPS_READ;
                        end else begin
                            idx_ff <= idx_ff + 3'h1;
                            state_ff <= FPS_CMD;
                        end
                    end
                end
                FPS_LOAD: begin
                    wait_ff <= wait_ff + 33'h1;
                    if (wait_ff >= LOAD_CYC - 1) begin
                        state_ff <= FPS_READ;
                    end
                end
                FPS_READ: begin
                    stb_ff <= stb_ff + 5'h01;
                    wait_ff <= wait_ff + 33'h1;
                    if (stb_ff == 5'(`FPS_STROBE_CYC - 1)) begin
                        stb_ff <= 5'h00;
                        prev_ff <= i_flash_dq;
                        have_prev_ff <= 1'b1;
                        if (done_now) begin
                            state_ff <= FPS_DONE;
                        end else if (wait_ff >= op_limit) begin
                            state_ff <= FPS_DONE;
                        end else begin
                            state_ff <= FPS_READ_GAP;
                        end
                    end
                end
                FPS_READ_GAP: begin
                    stb_ff <= stb_ff + 5'h01;
                    wait_ff <= wait_ff + 33'h1;
                    if (stb_ff == 5'(`FPS_STROBE_CYC - 1)) begin
                        stb_ff <= 5'h00;
                        state_ff <= FPS_READ;
                    end
                end
                FPS_OE_LEAD: begin
                    wait_ff <= wait_ff + 33'h1;
                    if (wait_ff >= OELEAD_CYC - 1) begin
                        wait_ff <= 33'h0;
                        state_ff <= FPS_PULSE;
                    end
                end
                FPS_PULSE: begin
                    wait_ff <= wait_ff + 33'h1;
                    if (wait_ff >= ((op_ff == FPS_OP_PROT) ?
                        PROT_CYC : UNPROT_CYC) - 1) begin
                        state_ff <= FPS_DONE;
                    end
                end
                FPS_DONE: begin
                    state_ff <= FPS_IDLE;
                end
                default: begin
                    state_ff <= FPS_IDLE;
                end
            endcase
        end
    end

    // Counts poll cycles so a timeout can be reported.
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            cnt_ff <= 33'h0;
        end else if (state_ff == FPS_IDLE) begin
            cnt_ff <= 33'h0; // A protect run must not see an old count.
        end else begin
            cnt_ff <= (state_ff == FPS_READ) ? wait_ff : cnt_ff;
        end
    end

    // ----------------------------------------
    // Pin and status outputs
    // ----------------------------------------
    // Registered pin drive derived from the current state, one cycle behind it.
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            o_flash_addr <= 17'h00000;
            o_flash_dq <= 8'h00;
            o_flash_dq_oe <= 1'b0;
            o_flash_ce_n <= 1'b1;
            o_flash_oe_n <= 1'b1;
            o_flash_we_n <= 1'b1;
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_timeout <= 1'b0;
        end else begin
            o_busy <= (state_ff != FPS_IDLE);
            o_done <= (state_ff == FPS_DONE);
            o_timeout <= (state_ff == FPS_DONE) && (cnt_ff >= op_limit);
            o_flash_ce_n <= !(state_ff == FPS_CMD || state_ff == FPS_READ ||
                state_ff == FPS_OE_LEAD || state_ff == FPS_PULSE);
            o_flash_we_n <= !(state_ff == FPS_CMD ||
                state_ff == FPS_PULSE);
            o_flash_oe_n <= !(state_ff == FPS_READ);
            o_flash_dq_oe <= (state_ff == FPS_CMD);
            o_flash_dq <= cmd_data(op_ff, idx_ff, data_ff);
            o_flash_addr <= (state_ff == FPS_READ) ? addr_ff :
                cmd_addr(op_ff, idx_ff, addr_ff);
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_pulse_width: assert property (
        @(posedge i_clock) disable iff (!i_rstn)
        $rose(state_ff == FPS_PULSE) |-> (state_ff == FPS_PULSE)[*8])
        else $error("protect pulse ended too early");
    a_load_wait: assert property (
        @(posedge i_clock) disable iff (!i_rstn)
        (state_ff == FPS_LOAD && $past(state_ff) == FPS_CMD_GAP) |->
        (state_ff == FPS_LOAD)[*8])
        else $error("sector load window too short");
    a_oe_lead: assert property (
        @(posedge i_clock) disable iff (!i_rstn)
        $rose(state_ff == FPS_PULSE) |-> $past(state_ff) == FPS_OE_LEAD)
        else $error("write pulse without output enable lead");
    a_one_byte: assert property (
        @(posedge i_clock) disable iff (!i_rstn)
        (state_ff == FPS_CMD && op_ff == FPS_OP_PROG) |-> idx_ff <= 3'h3)
        else $error("program wrote more than one byte");
    a_done_pulse: assert property (
        @(posedge i_clock) disable iff (!i_rstn)
        o_done |=> !o_done)
        else $error("done held longer than a cycle");
    a_reset_idle: assert property (
        @(posedge i_clock)
        !i_rstn |=> state_ff == FPS_IDLE)
        else $error("not idle after reset");
    a_no_we_read: assert property (
        @(posedge i_clock) disable iff (!i_rstn)
        !(o_flash_we_n == 1'b0 && o_flash_oe_n == 1'b0))
        else $error("write and read strobes together");
    a_drive_cmd: assert property (
        @(posedge i_clock) disable iff (!i_rstn)
        o_flash_dq_oe |-> !o_flash_we_n)
        else $error("data driven outside a command write");

endmodule

// ==== src/fps_map.svh ====
// Constants for the flash program and erase host controller.
`ifndef FPS_MAP_SVH
`define FPS_MAP_SVH

// ----------------------------------------
// Clock, timing, status bits and sector field
// ----------------------------------------
`define FPS_CLK_MHZ 250
`define FPS_PROG_MAX_US 210
`define FPS_CHIP_MAX_S 24
`define FPS_SECT_MAX_S 8
`define FPS_LOAD_US 100
`define FPS_PROT_US 10
`define FPS_UNPROT_MS 12
`define FPS_OELEAD_US 4
`define FPS_CYC_US(x) ((x) * `FPS_CLK_MHZ)
`define FPS_STROBE_CYC 16
`define FPS_TOGGLE_BIT 6
`define FPS_POLL_BIT 7
`define FPS_SECT_LO 13
`define FPS_SECT_HI 16

`endif

// ==== src/fps_pkg.sv ====
// Types for the flash program and erase host controller.
package fps_pkg;
    typedef enum logic [3:0] {
        FPS_IDLE = 4'h0,
        FPS_CMD = 4'h1,
        FPS_CMD_GAP = 4'h2,
        FPS_LOAD = 4'h3,
        FPS_READ = 4'h4,
        FPS_READ_GAP = 4'h5,
        FPS_OE_LEAD = 4'h6,
        FPS_PULSE = 4'h7,
        FPS_DONE = 4'h8
    } fps_state_e;

    typedef enum logic [2:0] {
        FPS_OP_PROG = 3'h0,
        FPS_OP_CHIP = 3'h1,
        FPS_OP_SECT = 3'h2,
        FPS_OP_PROT = 3'h3,
        FPS_OP_UNPROT = 3'h4
    } fps_op_e;
endpackage

// ==== verification/flash_auto_program_erase_status_bench.sv ====
// Self-checking bench for the flash program and erase host controller.
`timescale 1ns/1ps

module flash_auto_program_erase_status_bench;
    import fps_pkg::*;
    localparam int PROG = 2000;
    localparam int LOAD = 200;
    localparam int PROT = 40;
    localparam int UNPROT = 80;
    localparam int LEAD = 16;
    logic i_clock = 1'b0;
    logic i_rstn = 1'b0;
    logic i_start = 1'b0;
    logic [2:0] i_op = 3'h0;
    logic [16:0] i_addr = 17'h00000;
    logic [7:0] i_data = 8'h00;
    logic i_use_toggle = 1'b0;
    logic o_busy, o_done, o_timeout, o_flash_dq_oe;
    logic o_flash_ce_n, o_flash_oe_n, o_flash_we_n;
    logic [16:0] o_flash_addr;
    logic [7:0] i_flash_dq, o_flash_dq;
    logic [15:0] dur = 16'h0064;
    logic [7:0] shadow [0:131071];
    logic [31:0] seed = 32'h00017B37;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;
    int dones = 0;
    int lead = 0;
    int wlen = 0;
    int last_lead = 0;
    int last_w = 0;

    // Clock of 4 ns period.
    always #2 i_clock = ~i_clock;

    fps_host #(.CHIP_CYC(4000), .SECT_CYC(3000), .PROG_CYC(PROG),
        .LOAD_CYC(LOAD), .PROT_CYC(PROT), .UNPROT_CYC(UNPROT),
        .OELEAD_CYC(LEAD)) fps_host_i (
        .i_clock(i_clock), .i_rstn(i_rstn), .i_start(i_start),
        .i_op(i_op), .i_addr(i_addr), .i_data(i_data),
        .i_use_toggle(i_use_toggle), .o_busy(o_busy), .o_done(o_done),
        .o_timeout(o_timeout), .o_flash_addr(o_flash_addr),
        .i_flash_dq(i_flash_dq), .o_flash_dq(o_flash_dq),
        .o_flash_dq_oe(o_flash_dq_oe), .o_flash_ce_n(o_flash_ce_n),
        .o_flash_oe_n(o_flash_oe_n), .o_flash_we_n(o_flash_we_n));

    fps_flash_model fps_flash_model_i (
        .i_clock(i_clock), .i_addr(o_flash_addr), .i_dq(o_flash_dq),
        .i_ce_n(o_flash_ce_n), .i_oe_n(o_flash_oe_n),
        .i_we_n(o_flash_we_n), .i_dur(dur), .o_dq(i_flash_dq), .o_gap());

    // Measures strobe widths, enable lead time and completion pulses.
    always @(posedge i_clock) begin
        cyc <= cyc + 1;
        if (o_done === 1'b1) dones <= dones + 1;
        lead <= (o_flash_ce_n || !o_flash_we_n) ? 0 : lead + 1;
        wlen <= o_flash_we_n ? 0 : wlen + 1;
        if (!o_flash_we_n && wlen == 0) last_lead <= lead;
        if (o_flash_we_n && wlen != 0) last_w <= wlen;
        if (cyc == 80000) begin
            err_total = err_total + 1;
            finish_test();
        end
    end

    // Next value of the stimulus shift register.
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Byte the array should hold after the operations so far.
    function automatic logic [7:0] exp_byte(input logic [16:0] a);
        return shadow[a];
    endfunction

    // Byte that the flash model holds at one address.
    function automatic logic [7:0] held(input logic [16:0] a);
        return fps_flash_model_i.mem[a];
    endfunction

    // Compares one value and reports a mismatch.
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic finish_test();
        $display("Compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Runs one operation with a refused start poked in while busy.
    task automatic run(input logic [2:0] op, input logic [16:0] a,
        input logic [7:0] d, input logic [15:0] t, input logic to);
        int n;
        n = 0;
        seed = lfsr(seed);
        dur = t;
        i_op = op;
        i_addr = a;
        i_data = d;
        // Sector erase always ends by toggle, chip erase always by polling.
        i_use_toggle = (op == FPS_OP_SECT) || (op != FPS_OP_CHIP && seed[0]);
        i_start = 1'b1;
        @(negedge i_clock);
        i_start = 1'b0;
        dones = 0;
        repeat (4) @(negedge i_clock);
        i_start = 1'b1;
        i_op = FPS_OP_CHIP;
        @(negedge i_clock);
        i_start = 1'b0;
        i_op = op;
        while (o_done !== 1'b1 && n < 60000) begin
            @(negedge i_clock);
            n++;
        end
        check("timeout flag", o_timeout, to);
        repeat (40) @(negedge i_clock);
        check("done pulses", dones, 1);
        check("busy", o_busy, 0);
    endtask

    // Main sequence.
    initial begin
        logic [16:0] a;
        logic [7:0] d;
        foreach (shadow[i]) shadow[i] = 8'hFF;
        repeat (5) @(negedge i_clock);
        i_rstn = 1'b1;
        // Random bytes to distinct places, slow and quick device answers.
        for (int k = 0; k < 6; k++) begin
            seed = lfsr(seed);
            a = {seed[16:4], k[3:0]};
            d = (k == 0) ? 8'h00 : (k == 1) ? 8'h7F : seed[31:24];
            run(FPS_OP_PROG, a, d, {6'h00, seed[9:0]} + 16'h0014, 1'b0);
            shadow[a] = d;
            check("program byte", held(a), exp_byte(a));
            check("neighbour", held(a ^ 17'h00010),
                exp_byte(a ^ 17'h00010));
        end
        // Sector erase clears its own sector and leaves the next one.
        run(FPS_OP_PROG, 17'h0A123, 8'h5A, 16'h0100, 1'b0);
        run(FPS_OP_PROG, 17'h0C123, 8'hA5, 16'h0080, 1'b0);
        run(FPS_OP_SECT, 17'h0A000, 8'h00, 16'h0200, 1'b0);
        check("sector byte", held(17'h0A123), 8'hFF);
        check("other sector", held(17'h0C123), 8'hA5);
        check("load window", fps_flash_model_i.o_gap >= LOAD, 1);
        // Chip erase clears everything.
        run(FPS_OP_CHIP, 17'h00000, 8'h00, 16'h0300, 1'b0);
        check("chip byte", held(17'h0C123), 8'hFF);
        check("chip random", held(a), 8'hFF);
        // A device slower than the limit must be reported.
        run(FPS_OP_PROG, 17'h00040, 8'h3C, 16'h0FA0, 1'b1);
        repeat (4100) @(negedge i_clock);
        // Protect and unprotect pulse shapes.
        run(FPS_OP_PROT, 17'h00000, 8'h00, 16'h0000, 1'b0);
        check("protect width", last_w >= PROT, 1);
        check("enable lead", last_lead >= LEAD, 1);
        run(FPS_OP_UNPROT, 17'h00000, 8'h00, 16'h0000, 1'b0);
        check("unprotect width", last_w >= UNPROT, 1);
        finish_test();
    end
endmodule

// ==== verification/fps_flash_model.sv ====
// Behavioural flash device model answering the host controller pins.
`timescale 1ns/1ps

module fps_flash_model (
    // Clock used to sample the pins.
    input wire logic i_clock,
    // Pins from the host, and the busy time set by the bench.
    input wire logic [16:0] i_addr,
    input wire logic [7:0] i_dq,
    input wire logic i_ce_n,
    input wire logic i_oe_n,
    input wire logic i_we_n,
    input wire logic [15:0] i_dur,
    // Answer to the host, and the gap from the last command write to the first read.
    output logic [7:0] o_dq,
    output int o_gap
);
    logic [7:0] mem [0:131071];
    logic [7:0] wd, pd, rd;
    logic [16:0] wa;
    logic we_q = 1'b1;
    logic oe_q = 1'b1;
    logic tgl = 1'b0;
    logic is_prog = 1'b0;
    logic seen = 1'b1;
    int step = 0;
    int busy = 0;
    int cyc = 0;
    int t_cmd = 0;

    // The array powers up erased and in read mode.
    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
        rd = 8'hFF;
        o_gap = 0;
    end

    // Decodes one write; contents change only after a full sequence.
    task automatic take(input logic [16:0] a, input logic [7:0] d);
        logic [11:0] la;
        la = a[11:0];
        if (busy != 0) return;
        t_cmd = cyc;
        seen = 1'b0;
        if (step == 3) begin
            mem[a] = d;
            pd = d;
            is_prog = 1'b1;
            busy = int'(i_dur);
            step = 0;
        end else if (step == 6 && d == 8'h10) begin
            foreach (mem[i]) mem[i] = 8'hFF;
            is_prog = 1'b0;
            busy = int'(i_dur);
            step = 0;
        end else if (step == 6 && d == 8'h30) begin
            for (int i = 0; i < 8192; i++) mem[{a[16:13], i[12:0]}] = 8'hFF;
            is_prog = 1'b0;
            busy = int'(i_dur);
            step = 0;
        end else if (step == 2 && la == 12'h555 && d == 8'hA0) begin
            step = 3;
        end else if (step == 2 && la == 12'h555 && d == 8'h80) begin
            step = 4;
        end else if (((step == 0 || step == 4) && la == 12'h555 && d == 8'hAA)
            || ((step == 1 || step == 5) && la == 12'h2AA && d == 8'h55)) begin
            step = step + 1;
        end else begin
            step = 0;
        end
    endtask

    // Pins are sampled on the falling edge, away from the host's updates.
    always @(negedge i_clock) begin
        if (busy != 0) busy = busy - 1;
        if (!i_we_n && !i_ce_n) begin
            wa = i_addr;
            wd = i_dq;
        end
        if (i_we_n && !we_q) take(wa, wd);
        if (!i_oe_n && oe_q && !i_ce_n) begin
            if (!seen) begin
                o_gap = cyc - t_cmd;
                seen = 1'b1;
            end
            if (busy != 0) begin
                tgl = ~tgl;
                rd = {is_prog ? ~pd[7] : 1'b0, tgl, pd[5:0]};
            end else begin
                rd = mem[i_addr];
            end
        end
        we_q = i_we_n;
        oe_q = i_oe_n;
        cyc = cyc + 1;
    end

    // A released bus shows the inverse of the last value, not a held copy.
    assign o_dq = (!i_oe_n && !i_ce_n) ? rd : ~rd;
endmodule
